/* File: hw/cpu_instr_exec.sv */
/*
 Execution core for a subset of an 8-bit controller's instructions:
 watchdog kick, call through the accumulator, file complement, clear,
 decrement, accumulator clear, and increment/decrement with skip.
 Assumes the fetch side offers one instruction at a time with
 i_instr_valid and holds it until o_instr_ready; all inputs are
 synchronous to i_clk.
 The high latch value arrives as a port and is captured when the
 instruction is taken, so later changes on it do not disturb a call.
 i_sleep_enter may be a level or a pulse; each cycle it is high the
 sleep flag drops, unless a watchdog kick completes in that cycle.
 Only push is used on the return stack; return is outside this subset.
 File register banking is outside this block: addresses are direct.
*/
`timescale 1ns/1ps
//
// Contract
// - Watchdog kick zeroes the watchdog counter.
// - Watchdog kick also zeroes the prescaler feeding that counter.
// - Watchdog kick sets expiry and sleep flags to one, nothing else.
// - Indirect call pushes current address plus one as new stack top.
// - Then accumulator loads PC low byte, high latch loads PC bits 14:8.
// - Indirect call takes two instruction cycles and keeps every flag.
// - Destination bit zero writes accumulator, one writes the file register.
// - Invert writes complement of the file register and updates null flag.
// - Zero file clears the addressed register and sets null flag.
// - Minus one writes file register less one and updates null flag.
// - Zero accumulator clears accumulator and sets null flag.
// - Decrement with skip touches no flag; zero result makes next a no-op.
// - Increment with skip touches no flag; zero result discards next one.
module cpu_instr_exec #(
   parameter int PRESCALE_W = exec_subset_pkg::PRESCALE_W,
   parameter int STACK_DEPTH = exec_subset_pkg::STACK_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_instr_valid,
   input wire exec_subset_pkg::op_type i_opcode,
   input wire logic [exec_subset_pkg::ADDR_W-1:0] i_file_addr,
   input wire logic i_dest_sel,
   input wire logic [exec_subset_pkg::LATCH_W-1:0] i_pc_high_latch,
   input wire logic i_sleep_enter,
   output logic o_instr_ready,
   output logic [exec_subset_pkg::PC_W-1:0] o_pc,
   output logic [exec_subset_pkg::DATA_W-1:0] o_accumulator,
   output logic o_result_null_flag,
   output logic o_watchdog_expiry_flag,
   output logic o_sleep_entered_flag,
   output logic [exec_subset_pkg::DATA_W-1:0] o_watchdog_counter,
   output logic [exec_subset_pkg::PC_W-1:0] o_stack_top,
   output logic o_skip_pending
);
   // Whole core state in one record
   // op, addr, dest and latch hold the instruction taken at fetch
   // pc counts handshake slots, including discarded ones
   // skip marks that the next taken instruction runs as a no-operation
   // expiry and sleep flags are high while nothing has happened
   // prescale and wdt form the free-running watchdog time base
   typedef struct packed {
      exec_subset_pkg::state_type state;
      exec_subset_pkg::op_type op;
      logic [exec_subset_pkg::ADDR_W-1:0] addr;
      logic dest;
      logic [exec_subset_pkg::LATCH_W-1:0] latch;
      logic [exec_subset_pkg::PC_W-1:0] pc;
      logic [exec_subset_pkg::DATA_W-1:0] acc;
      logic null_flag;
      logic expiry_flag;
      logic sleep_flag;
      logic skip;
      logic [PRESCALE_W-1:0] prescale;
      logic [exec_subset_pkg::DATA_W-1:0] wdt;
   } core_state_type;

   core_state_type state_reg;
   core_state_type state_next;
   logic [exec_subset_pkg::DATA_W-1:0] result;
   logic result_valid;
   logic prescale_wrap;
   logic wdt_wrap;

   file_mem_if mem_bus ();
   ret_stack_if stack_bus ();

   if (PRESCALE_W < 1 || PRESCALE_W > 16) begin : g_prescale_check
      $error("cpu_instr_exec prescaler width must be 1 to 16");
   end

   file_reg_mem #(
      .DEPTH(exec_subset_pkg::FILE_DEPTH)
   ) u_file_mem (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .bus(mem_bus)
   );

   return_stack #(
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .bus(stack_bus)
   );

   // Result of the file operations, from the registered read data
   // The read is issued at fetch, so the data stands in execute only
   // Ops without a file result flag result_valid low so that the result
   // is not written; zero file and zero accumulator clear their target directly
   always_comb begin
      result = mem_bus.rd_data;
      result_valid = 1'b1;
      case (state_reg.op)
         exec_subset_pkg::OP_INVERT_FILE: begin
            result = ~mem_bus.rd_data;
         end
         exec_subset_pkg::OP_MINUS_ONE_FILE,
         exec_subset_pkg::OP_MINUS_ONE_SKIP: begin
            result = mem_bus.rd_data - exec_subset_pkg::DATA_ONE;
         end
         exec_subset_pkg::OP_PLUS_ONE_SKIP: begin
            result = mem_bus.rd_data + exec_subset_pkg::DATA_ONE;
         end
         default: begin
            result_valid = 1'b0;
         end
      endcase
   end

   // Free-running watchdog time base; expiry drops the flag to zero
   // The counter steps once per full prescaler period
   // Expiry is the cycle where both prescaler and counter are all ones
   // Limitation: the counter wraps and keeps running after an expiry,
   // only the flag remembers it until the next kick
   always_comb begin
      prescale_wrap = &state_reg.prescale;
      wdt_wrap = prescale_wrap && (&state_reg.wdt);
   end

   // Next state of the whole core
   // Time base and event flags update first, every cycle
   // The instruction sequencer then overrides what it owns
   // A normal op takes fetch plus execute; a call adds a second cycle
   // A discarded instruction is taken and retired in its fetch slot,
   // so it takes one clock where a run instruction takes two, and a call three
   always_comb begin
      state_next = state_reg;
      state_next.prescale = state_reg.prescale + PRESCALE_W'(1);
      if (prescale_wrap) begin
         state_next.wdt = state_reg.wdt + exec_subset_pkg::DATA_ONE;
      end
      if (wdt_wrap) begin
         state_next.expiry_flag = 1'b0;
      end
      if (i_sleep_enter) begin
         state_next.sleep_flag = 1'b0;
      end
      case (state_reg.state)
         exec_subset_pkg::ST_FETCH: begin
            // Capture operands only for an instruction that will run
            // A discarded one only clears skip and advances the program counter
            if (i_instr_valid && state_reg.skip) begin
               // Discarded instruction runs as a no-operation
               state_next.skip = 1'b0;
               state_next.pc = state_reg.pc + exec_subset_pkg::PC_STEP;
            end else if (i_instr_valid) begin
               state_next.op = i_opcode;
               state_next.addr = i_file_addr;
               state_next.dest = i_dest_sel;
               state_next.latch = i_pc_high_latch;
               state_next.state = exec_subset_pkg::ST_EXECUTE;
            end
         end
         exec_subset_pkg::ST_EXECUTE: begin
            // Default is to retire and step to the next address
            // The call below replaces the step with its target
            state_next.state = exec_subset_pkg::ST_FETCH;
            state_next.pc = state_reg.pc + exec_subset_pkg::PC_STEP;
            case (state_reg.op)
               exec_subset_pkg::OP_KICK_WATCHDOG: begin
                  state_next.wdt = exec_subset_pkg::DATA_ZERO;
                  state_next.prescale = PRESCALE_W'(exec_subset_pkg::PRESCALE_ZERO);
                  // Kick wins over a same-cycle expiry or sleep event
                  state_next.expiry_flag = 1'b1;
                  state_next.sleep_flag = 1'b1;
               end
               exec_subset_pkg::OP_INDIRECT_CALL: begin
                  // Push handled below; flags are left alone
                  state_next.pc = {state_reg.latch, state_reg.acc};
                  state_next.state = exec_subset_pkg::ST_SECOND;
               end
               exec_subset_pkg::OP_INVERT_FILE,
               exec_subset_pkg::OP_MINUS_ONE_FILE: begin
                  state_next.null_flag = (result == exec_subset_pkg::DATA_ZERO);
               end
               exec_subset_pkg::OP_ZERO_FILE: begin
                  state_next.null_flag = 1'b1;
               end
               exec_subset_pkg::OP_ZERO_ACCUMULATOR: begin
                  state_next.acc = exec_subset_pkg::DATA_ZERO;
                  state_next.null_flag = 1'b1;
               end
               exec_subset_pkg::OP_MINUS_ONE_SKIP,
               exec_subset_pkg::OP_PLUS_ONE_SKIP: begin
                  state_next.skip = (result == exec_subset_pkg::DATA_ZERO);
               end
               default: begin
               end
            endcase
            if (result_valid && !state_reg.dest) begin
               state_next.acc = result;
            end
         end
         exec_subset_pkg::ST_SECOND: begin
            state_next.state = exec_subset_pkg::ST_FETCH;
         end
         default: begin
            state_next.state = exec_subset_pkg::ST_FETCH;
         end
      endcase
   end

   // Register the whole state; reset values are all constants
   // Status flags are high while nothing has happened, so they
   // come out of reset at their idle level
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= '0;
         state_reg.state <= exec_subset_pkg::ST_FETCH;
         state_reg.op <= exec_subset_pkg::OP_NO_OPERATION;
         state_reg.pc <= exec_subset_pkg::PC_RESET;
         state_reg.expiry_flag <= exec_subset_pkg::FLAG_IDLE_VALUE;
         state_reg.sleep_flag <= exec_subset_pkg::FLAG_IDLE_VALUE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Read is issued at fetch so data is registered by the execute cycle
   // The write of one op lands at its execute edge, before the next
   // op can be fetched, so a read never sees stale data
   // Zero file ignores the destination bit and always writes the file
   always_comb begin
      mem_bus.rd_en = (state_reg.state == exec_subset_pkg::ST_FETCH) && i_instr_valid;
      mem_bus.rd_addr = i_file_addr;
      mem_bus.wr_en = 1'b0;
      mem_bus.wr_addr = state_reg.addr;
      mem_bus.wr_data = result;
      if (state_reg.state == exec_subset_pkg::ST_EXECUTE) begin
         if (state_reg.op == exec_subset_pkg::OP_ZERO_FILE) begin
            mem_bus.wr_en = 1'b1;
            mem_bus.wr_data = exec_subset_pkg::DATA_ZERO;
         end else if (result_valid && state_reg.dest) begin
            mem_bus.wr_en = 1'b1;
         end
      end
   end

   // Return address is the call's own address plus one
   // Pushed at the execute edge, together with the jump
   always_comb begin
      stack_bus.push = (state_reg.state == exec_subset_pkg::ST_EXECUTE)
         && (state_reg.op == exec_subset_pkg::OP_INDIRECT_CALL);
      stack_bus.push_addr = state_reg.pc + exec_subset_pkg::PC_STEP;
   end

   // Outputs
   // Ready is a handshake output and may be combinational
   // All data outputs come straight from state registers
   assign o_instr_ready = (state_reg.state == exec_subset_pkg::ST_FETCH);
   assign o_pc = state_reg.pc;
   assign o_accumulator = state_reg.acc;
   assign o_result_null_flag = state_reg.null_flag;
   assign o_watchdog_expiry_flag = state_reg.expiry_flag;
   assign o_sleep_entered_flag = state_reg.sleep_flag;
   assign o_watchdog_counter = state_reg.wdt;
   assign o_stack_top = stack_bus.top;
   assign o_skip_pending = state_reg.skip;
endmodule

/* File: hw/exec_links_if.sv */
/*
 Interfaces joining the execution core to its file register memory
 and to its return stack.
 Assumes a single clock shared by all three modules.
*/
`timescale 1ns/1ps
interface file_mem_if;
   logic rd_en;
   logic [exec_subset_pkg::ADDR_W-1:0] rd_addr;
   logic [exec_subset_pkg::DATA_W-1:0] rd_data;
   logic wr_en;
   logic [exec_subset_pkg::ADDR_W-1:0] wr_addr;
   logic [exec_subset_pkg::DATA_W-1:0] wr_data;
   modport core (output rd_en, rd_addr, wr_en, wr_addr, wr_data, input rd_data);
   modport mem (input rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface

interface ret_stack_if;
   logic push;
   logic [exec_subset_pkg::PC_W-1:0] push_addr;
   logic [exec_subset_pkg::PC_W-1:0] top;
   modport core (output push, push_addr, input top);
   modport stack (input push, push_addr, output top);
endinterface

/* File: hw/exec_subset_pkg.sv */
/*
 Shared constants and types for the instruction execution subset:
 widths, reset values, opcode and state encodings.
 Assumes nothing of its surroundings; used by every design file.
*/
package exec_subset_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 15;
   localparam int PC_LOW_W = 8;
   localparam int LATCH_W = 7;
   localparam int ADDR_W = 7;
   localparam int FILE_DEPTH = 128;
   localparam int STACK_DEPTH = 16;
   localparam int PRESCALE_W = 8;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
   localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
   localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = 8'h00;
   localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;
   localparam logic FLAG_IDLE_VALUE = 1'b1;

   // Opcodes presented by the fetch side
   typedef enum logic [3:0] {
      OP_NO_OPERATION = 4'h0,
      OP_KICK_WATCHDOG = 4'h1,
      OP_INDIRECT_CALL = 4'h2,
      OP_INVERT_FILE = 4'h3,
      OP_ZERO_FILE = 4'h4,
      OP_MINUS_ONE_FILE = 4'h5,
      OP_ZERO_ACCUMULATOR = 4'h6,
      OP_MINUS_ONE_SKIP = 4'h7,
      OP_PLUS_ONE_SKIP = 4'h8
   } op_type;

   // Gray coded along fetch, execute, second cycle
   typedef enum logic [1:0] {
      ST_FETCH = 2'b00,
      ST_EXECUTE = 2'b01,
      ST_SECOND = 2'b11
   } state_type;
endpackage

/* File: hw/file_reg_mem.sv */
/*
 File register memory: one read port with registered data, one write port.
 Assumes read and write requests are synchronous to i_clk.
*/
`timescale 1ns/1ps
module file_reg_mem #(
   parameter int DEPTH = exec_subset_pkg::FILE_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   file_mem_if.mem bus
);
   typedef struct packed {
      logic [DEPTH-1:0][exec_subset_pkg::DATA_W-1:0] cells;
      logic [exec_subset_pkg::DATA_W-1:0] rd_data;
   } mem_state_type;

   mem_state_type state_reg;
   mem_state_type state_next;

   if (DEPTH < 1 || DEPTH > (1 << exec_subset_pkg::ADDR_W)) begin : g_depth_check
      $error("file_reg_mem depth does not fit the address width");
   end

   // Read sees the old contents when reading and writing the same cell
   always_comb begin
      state_next = state_reg;
      if (bus.wr_en) begin
         state_next.cells[bus.wr_addr] = bus.wr_data;
      end
      if (bus.rd_en) begin
         state_next.rd_data = state_reg.cells[bus.rd_addr];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus.rd_data = state_reg.rd_data;
endmodule

/* File: hw/return_stack.sv */
/*
 Circular return address stack; only push is used by this subset.
 Assumes push requests are synchronous to i_clk; overflow wraps silently.
*/
`timescale 1ns/1ps
module return_stack #(
   parameter int DEPTH = exec_subset_pkg::STACK_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   ret_stack_if.stack bus
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][exec_subset_pkg::PC_W-1:0] slots;
      logic [PTR_W-1:0] ptr;
      logic [exec_subset_pkg::PC_W-1:0] top;
   } stack_state_type;

   stack_state_type state_reg;
   stack_state_type state_next;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
      $error("return_stack depth must be a power of two of at least 2");
   end

   // Pointer wraps, so a deep call chain overwrites the oldest entry
   always_comb begin
      state_next = state_reg;
      if (bus.push) begin
         state_next.ptr = state_reg.ptr + PTR_W'(1);
         state_next.slots[state_next.ptr] = bus.push_addr;
         state_next.top = bus.push_addr;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus.top = state_reg.top;
endmodule

/* File: test/cpu_instr_exec_properties.sv */
/*
 Concurrent checks on the ports of the instruction execution core.
 Assumes the bind below attaches it to every cpu_instr_exec instance.
*/
`timescale 1ns/1ps
module cpu_instr_exec_properties (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_instr_valid,
   input wire exec_subset_pkg::op_type i_opcode,
   input wire logic i_dest_sel,
   input wire logic [exec_subset_pkg::LATCH_W-1:0] i_pc_high_latch,
   input wire logic o_instr_ready,
   input wire logic [exec_subset_pkg::PC_W-1:0] o_pc,
   input wire logic [exec_subset_pkg::DATA_W-1:0] o_accumulator,
   input wire logic o_result_null_flag,
   input wire logic o_watchdog_expiry_flag,
   input wire logic o_sleep_entered_flag,
   input wire logic [exec_subset_pkg::DATA_W-1:0] o_watchdog_counter,
   input wire logic [exec_subset_pkg::PC_W-1:0] o_stack_top,
   input wire logic o_skip_pending
);
   logic go;
   logic call;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // A taken instruction that is not discarded; results land one edge later
   assign go = i_instr_valid && o_instr_ready && !o_skip_pending;
   assign call = go && i_opcode == exec_subset_pkg::OP_INDIRECT_CALL;
   op_length_a: assert property (go && !call |=> !o_instr_ready ##1 o_instr_ready)
      else $error("plain instruction length wrong");
   call_length_a: assert property (call |=> !o_instr_ready [*2] ##1 o_instr_ready)
      else $error("call length wrong");
   call_target_a: assert property (call |=> ##1 o_stack_top == $past(o_pc, 2) + 15'h0001
      && o_pc == {$past(i_pc_high_latch, 2), $past(o_accumulator, 2)})
      else $error("call target or return address wrong");
   call_flags_a: assert property (call |=> ##1
      o_result_null_flag == $past(o_result_null_flag, 2)) else $error("call changed a flag");
   skip_drop_a: assert property (i_instr_valid && o_instr_ready && o_skip_pending |=>
      o_instr_ready && !o_skip_pending && o_pc == $past(o_pc) + 15'h0001)
      else $error("discarded instruction mishandled");
   kick_state_a: assert property (go && i_opcode == exec_subset_pkg::OP_KICK_WATCHDOG |=> ##1
      o_watchdog_counter == 8'h00 && o_watchdog_expiry_flag && o_sleep_entered_flag)
      else $error("watchdog kick result wrong");
   // Prescaler cleared too, so the counter holds zero for at least four cycles
   kick_hold_a: assert property (go && i_opcode == exec_subset_pkg::OP_KICK_WATCHDOG |=> ##1
      (o_watchdog_counter == 8'h00) [*4]) else $error("watchdog stepped early after kick");
   zero_acc_a: assert property (go && i_opcode == exec_subset_pkg::OP_ZERO_ACCUMULATOR |=> ##1
      o_accumulator == 8'h00 && o_result_null_flag) else $error("accumulator clear wrong");
   zero_file_a: assert property (go && i_opcode == exec_subset_pkg::OP_ZERO_FILE |=> ##1
      o_result_null_flag && o_accumulator == $past(o_accumulator, 2))
      else $error("file clear wrong");
   skip_flags_a: assert property (go && (i_opcode == exec_subset_pkg::OP_MINUS_ONE_SKIP
      || i_opcode == exec_subset_pkg::OP_PLUS_ONE_SKIP) |=> ##1
      o_result_null_flag == $past(o_result_null_flag, 2)) else $error("skip op touched a flag");
   null_track_a: assert property (go && !i_dest_sel && (i_opcode == exec_subset_pkg::OP_INVERT_FILE
      || i_opcode == exec_subset_pkg::OP_MINUS_ONE_FILE) |=> ##1
      o_result_null_flag == (o_accumulator == 8'h00)) else $error("null flag disagrees");
   pc_step_a: assert property (go && !call |=> ##1 o_pc == $past(o_pc, 2) + 15'h0001)
      else $error("program counter did not step");
endmodule

bind cpu_instr_exec cpu_instr_exec_properties props (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_instr_valid(i_instr_valid), .i_opcode(i_opcode), .i_dest_sel(i_dest_sel),
   .i_pc_high_latch(i_pc_high_latch), .o_instr_ready(o_instr_ready), .o_pc(o_pc),
   .o_accumulator(o_accumulator), .o_result_null_flag(o_result_null_flag),
   .o_watchdog_expiry_flag(o_watchdog_expiry_flag), .o_stack_top(o_stack_top),
   .o_sleep_entered_flag(o_sleep_entered_flag), .o_watchdog_counter(o_watchdog_counter),
   .o_skip_pending(o_skip_pending));

/* File: test/cpu_instr_exec_tb_top.sv */
/*
 Self-checking bench: directed corners, a watchdog run, then a seeded
 random instruction stream compared against a model of the core.
 Assumes package, interfaces, design and checker are compiled first.
*/
`timescale 1ns/1ps
module cpu_instr_exec_tb_top;
   localparam int PRE_W = 2;
   // Op in 11:8, destination in 7, address in 6:0
   localparam int DIR[18] = '{'h600, 'h305, 'h3ff, 'h57f, 'h47f, 'h5ff, 'h37f, 'h409, 'h889,
      'h789, 'h200, 'h38a, 'h80a, 'h100, 'h301, 'h200, 'h200, 'h100};
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_instr_valid = 1'b0;
   exec_subset_pkg::op_type i_opcode = exec_subset_pkg::OP_NO_OPERATION;
   logic [6:0] i_file_addr = 7'h00;
   logic i_dest_sel = 1'b0;
   logic [6:0] i_pc_high_latch = 7'h00;
   logic i_sleep_enter = 1'b0;
   logic o_instr_ready, o_result_null_flag, o_watchdog_expiry_flag;
   logic o_sleep_entered_flag, o_skip_pending;
   logic [14:0] o_pc, o_stack_top, pc, stk;
   logic [7:0] o_accumulator, o_watchdog_counter, acc;
   logic [7:0] mem[128];
   logic z, skp;
   int bad_count = 0;
   int cmp_count = 0;

   cpu_instr_exec #(.PRESCALE_W(PRE_W)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_instr_valid(i_instr_valid), .i_opcode(i_opcode), .i_file_addr(i_file_addr),
      .i_dest_sel(i_dest_sel), .i_pc_high_latch(i_pc_high_latch),
      .i_sleep_enter(i_sleep_enter), .o_instr_ready(o_instr_ready), .o_pc(o_pc),
      .o_accumulator(o_accumulator), .o_result_null_flag(o_result_null_flag),
      .o_watchdog_expiry_flag(o_watchdog_expiry_flag), .o_stack_top(o_stack_top),
      .o_sleep_entered_flag(o_sleep_entered_flag), .o_watchdog_counter(o_watchdog_counter),
      .o_skip_pending(o_skip_pending));

   always #5 i_clk = ~i_clk;

   task automatic chk(input string name, input logic [14:0] exp, input logic [14:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Ends at a falling edge with ready high; a hang is cut short here
   task automatic wait_ready();
      int n;
      n = 0;
      @(negedge i_clk);
      while (o_instr_ready !== 1'b1) begin
         n++;
         if (n > 20) begin
            bad_count++;
            end_sim();
         end
         @(negedge i_clk);
      end
   endtask

   function automatic logic [7:0] alu(input exec_subset_pkg::op_type op, input logic [7:0] f);
      case (op)
         exec_subset_pkg::OP_INVERT_FILE: return ~f;
         exec_subset_pkg::OP_PLUS_ONE_SKIP: return f + 8'h01;
         default: return f - 8'h01;
      endcase
   endfunction

   // Called at a rising edge; offers one instruction, updates the model, compares
   task automatic run_op(input exec_subset_pkg::op_type op, input logic [6:0] a, input logic d,
      input logic [6:0] lat);
      logic [7:0] r;
      logic was;
      i_opcode <= op;
      i_file_addr <= a;
      i_dest_sel <= d;
      i_pc_high_latch <= lat;
      i_instr_valid <= 1'b1;
      wait_ready();
      @(posedge i_clk);
      // Drop valid at the taking edge so the op is not taken twice
      i_instr_valid <= 1'b0;
      was = skp;
      r = alu(op, mem[a]);
      pc = pc + 15'h0001;
      skp = 1'b0;
      if (!was) begin
         case (op)
            exec_subset_pkg::OP_INDIRECT_CALL: begin
               stk = pc;
               pc = {lat, acc};
            end
            exec_subset_pkg::OP_ZERO_FILE: begin
               mem[a] = 8'h00;
               z = 1'b1;
            end
            exec_subset_pkg::OP_ZERO_ACCUMULATOR: begin
               acc = 8'h00;
               z = 1'b1;
            end
            exec_subset_pkg::OP_INVERT_FILE, exec_subset_pkg::OP_MINUS_ONE_FILE: begin
               if (d) mem[a] = r;
               else acc = r;
               z = (r == 8'h00);
            end
            exec_subset_pkg::OP_MINUS_ONE_SKIP, exec_subset_pkg::OP_PLUS_ONE_SKIP: begin
               if (d) mem[a] = r;
               else acc = r;
               skp = (r == 8'h00);
            end
            default: ;
         endcase
      end
      wait_ready();
      chk("pc", pc, o_pc);
      chk("acc", acc, o_accumulator);
      chk("null", z, o_result_null_flag);
      chk("stack_top", stk, o_stack_top);
      chk("skip", skp, o_skip_pending);
      if (op == exec_subset_pkg::OP_KICK_WATCHDOG && !was) begin
         chk("wdt", 8'h00, o_watchdog_counter);
         chk("wd_flags", 2'b11, {o_watchdog_expiry_flag, o_sleep_entered_flag});
         repeat (3) @(negedge i_clk);
         chk("wdt_hold", 8'h00, o_watchdog_counter);
      end
      @(posedge i_clk);
   endtask

   // Reset, directed corners, watchdog expiry, then random stream
   initial begin
      void'($urandom(32'h864f));
      foreach (mem[i]) mem[i] = 8'h00;
      {pc, stk, acc, z, skp} = '0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(negedge i_clk);
      chk("reset_flags", 5'b11001, {o_watchdog_expiry_flag, o_sleep_entered_flag,
         o_skip_pending, o_result_null_flag, o_instr_ready});
      @(posedge i_clk);
      for (int i = 0; i < 18; i++) begin
         run_op(exec_subset_pkg::op_type'(DIR[i][11:8]), DIR[i][6:0], DIR[i][7], 7'h7f);
      end
      // Counter wraps after 256 prescaler periods without a kick
      repeat ((1 << PRE_W) * 256 + 20) @(posedge i_clk);
      i_sleep_enter <= 1'b1;
      @(posedge i_clk);
      i_sleep_enter <= 1'b0;
      @(negedge i_clk);
      chk("expired", 2'b00, {o_watchdog_expiry_flag, o_sleep_entered_flag});
      @(posedge i_clk);
      run_op(exec_subset_pkg::OP_KICK_WATCHDOG, 7'h00, 1'b0, 7'h00);
      // Few addresses so reads hit earlier writes
      for (int i = 0; i < 400; i++) begin
         i_sleep_enter <= ($urandom_range(3) == 0);
         run_op(exec_subset_pkg::op_type'(4'($urandom_range(8))), 7'($urandom_range(3)),
            1'($urandom), 7'($urandom));
      end
      end_sim();
   end
endmodule
